// ==== verilog/mi_exec.sv ====
// Purpose: execute stage for a small subset of a 12-bit instruction set
// Assumes: fetch presents one instruction per cycle with its file operand
// Notes:   accumulator, zero flag and program counter live here
//          a discarded slot still steps pc, as fetch has already moved on
//
// Operation
// - increment-skip adds one to file register, result to dest, no flags
// - increment-skip with zero result discards next fetched instruction, two cycles
// - jump loads 9-bit operand into counter bits 8 down to 0
// - jump copies status bits 6 and 5 into counter bits 10 and 9
// - jump takes two cycles and changes no flags
// - or-literal ORs accumulator with literal into accumulator, updates zero
// - or-file ORs accumulator with file register to dest, updates zero
// - dest bit zero means accumulator, one means file register
// - store-accumulator copies accumulator into file register, no flags
// - move-file sends file register to dest, zero flag from value
// - move-file to itself keeps value, zero flag still updated
// - load-literal puts literal into accumulator, no flags
`timescale 1ns/1ps
module mi_exec
    import mi_exec_pkg::*;
(
    // clock and reset
    input  wire logic               clk,
    input  wire logic               srst,
    // from fetch
    input  wire logic               instrValid,
    input  wire logic [INSTR_W-1:0] instr,
    input  wire logic [DATA_W-1:0]  fileRdData,
    input  wire logic [PAGE_W-1:0]  statusPage,
    // to register file
    output logic                    fileWrEn,
    output logic [FADDR_W-1:0]      fileWrAddr,
    output logic [DATA_W-1:0]       fileWrData,
    // core state
    output logic [DATA_W-1:0]       acc,
    output logic                    zeroFlag,
    output logic                    zeroWrEn,
    output logic [PC_W-1:0]         pc,
    output logic                    squash,
    output logic                    illegal
);

    // sequencer: run, or drop the one slot that follows a redirect
    typedef enum logic {
        ST_RUN,
        ST_DISCARD
    } seq_e;

    // first match wins; the patterns do not overlap, so the order is free
    function automatic op_e decodeOp(input logic [INSTR_W-1:0] w);
        op_e o;
        o = OP_NOP;
        if ((w & STORE_MASK) == STORE_PAT) begin
            o = OP_STORE_ACC;
        end else if ((w & FD_MASK) == OR_F_PAT) begin
            o = OP_OR_FILE;
        end else if ((w & FD_MASK) == MOVE_F_PAT) begin
            o = OP_MOVE_FILE;
        end else if ((w & FD_MASK) == INC_SKZ_PAT) begin
            o = OP_INC_SKZ;
        end else if ((w & JUMP_MASK) == JUMP_PAT) begin
            o = OP_JUMP;
        end else if ((w & LIT_MASK) == LOAD_L_PAT) begin
            o = OP_LOAD_LIT;
        end else if ((w & LIT_MASK) == OR_L_PAT) begin
            o = OP_OR_LIT;
        end
        return o;
    endfunction : decodeOp

    // unknown words still run, as a nop, but raise the illegal pulse
    function automatic logic isKnown(input logic [INSTR_W-1:0] w);
        return ((w & NOP_MASK) == NOP_PAT) || (decodeOp(w) != OP_NOP);
    endfunction : isKnown

    // state registers
    seq_e                  seq_q;
    seq_e                  seq_d;
    logic [DATA_W-1:0]     acc_q;
    logic [DATA_W-1:0]     acc_d;
    logic                  zero_q;
    logic                  zero_d;
    logic                  zeroWr_q;
    logic                  zeroWr_d;
    logic [PC_W-1:0]       pc_q;
    logic [PC_W-1:0]       pc_d;
    logic                  fileWr_q;
    logic                  fileWr_d;
    logic [FADDR_W-1:0]    fileAddr_q;
    logic [DATA_W-1:0]     fileData_q;
    logic                  illegal_q;
    logic                  illegal_d;

    // decode and datapath nets
    wire  logic               discarding;
    wire  logic               execute;
    wire  op_e                opRaw;
    wire  op_e                op;
    wire  exec_s              res;
    wire  logic               isJump;
    wire  logic               skipTaken;
    wire  logic [FADDR_W-1:0] fileAddr;
    wire  logic [JUMP_W-1:0]  jumpField;
    wire  logic [PC_W-1:0]    jumpTarget;
    wire  logic [PC_W-1:0]    pcNext;

    // a discarded slot runs as a nop whatever was fetched into it
    assign discarding = (seq_q == ST_DISCARD);
    assign execute    = instrValid && !discarding;
    assign opRaw      = decodeOp(instr);
    assign op         = execute ? opRaw : OP_NOP;
    assign isJump     = (op == OP_JUMP);
    assign skipTaken  = res.skip;
    assign fileAddr   = instr[FADDR_LSB +: FADDR_W];
    assign jumpField  = instr[JUMP_W-1:0];
    // page bits come straight from status, no carry into them from the field
    assign jumpTarget = {statusPage, jumpField};
    assign pcNext     = pc_q + PC_STEP;

    // datapath sees a nop in any slot that does not execute
    mi_alu u_alu (
        .op     (op),
        .instr  (instr),
        .acc    (acc_q),
        .fileRd (fileRdData),
        .res    (res)
    );

    // next state; a slot with instrValid low leaves everything alone
    always_comb begin
        seq_d     = seq_q;
        acc_d     = res.accWr ? res.value : acc_q;
        zero_d    = res.zeroWr ? res.zero : zero_q;
        zeroWr_d  = res.zeroWr;
        fileWr_d  = res.fileWr;
        // illegal is judged only on slots that really execute
        illegal_d = execute && !isKnown(instr);
        pc_d      = pc_q;
        if (instrValid) begin
            unique case (seq_q)
                ST_RUN: begin
                    if (isJump) begin
                        // fetched successor is stale after a branch
                        pc_d  = jumpTarget;
                        seq_d = ST_DISCARD;
                    end else if (skipTaken) begin
                        pc_d  = pcNext;
                        seq_d = ST_DISCARD;
                    end else begin
                        pc_d  = pcNext;
                    end
                end
                ST_DISCARD: begin
                    // fetch now holds the target or the skipped word,
                    // so the counter steps past it as usual
                    pc_d  = pcNext;
                    seq_d = ST_RUN;
                end
            endcase
        end
    end

    // sequencer and program counter
    always_ff @(posedge clk) begin
        if (srst) begin
            seq_q <= ST_RUN;
            pc_q  <= PC_RST;
        end else begin
            seq_q <= seq_d;
            pc_q  <= pc_d;
        end
    end

    // accumulator and zero flag, the only core state written here
    always_ff @(posedge clk) begin
        if (srst) begin
            acc_q  <= ACC_RST;
            zero_q <= ZERO_RST;
        end else begin
            acc_q  <= acc_d;
            zero_q <= zero_d;
        end
    end

    // one-cycle strobes
    always_ff @(posedge clk) begin
        if (srst) begin
            zeroWr_q  <= 1'b0;
            illegal_q <= 1'b0;
        end else begin
            zeroWr_q  <= zeroWr_d;
            illegal_q <= illegal_d;
        end
    end

    // write-back port; address and data load every cycle, only the strobe matters
    always_ff @(posedge clk) begin
        if (srst) begin
            fileWr_q   <= 1'b0;
            fileAddr_q <= '0;
            fileData_q <= ACC_RST;
        end else begin
            fileWr_q   <= fileWr_d;
            fileAddr_q <= fileAddr;
            fileData_q <= res.value;
        end
    end

    // write-back is one cycle late; the register file must forward it
    assign fileWrEn   = fileWr_q;
    assign fileWrAddr = fileAddr_q;
    assign fileWrData = fileData_q;
    assign acc        = acc_q;
    assign zeroFlag   = zero_q;
    assign zeroWrEn   = zeroWr_q;
    assign pc         = pc_q;
    assign squash     = (seq_q == ST_DISCARD);
    assign illegal    = illegal_q;

endmodule : mi_exec

// ==== verilog/mi_exec_pkg.sv ====
// Purpose: shared constants and types for the instruction execute block
// Assumes: 12-bit instruction word, 8-bit data path, 11-bit program counter
// Notes:   opcode patterns are kept here so the decoder has them in one place
package mi_exec_pkg;

    localparam int INSTR_W    = 12;
    localparam int DATA_W     = 8;
    localparam int PC_W       = 11;
    localparam int FADDR_W    = 5;

    // operand field positions
    localparam int FADDR_LSB  = 0;
    localparam int DEST_BIT   = 5;
    localparam int LIT_LSB    = 0;
    localparam int JUMP_W     = 9;
    localparam int PAGE_W     = 2;

    // opcode patterns and the masks that select their fixed bits
    localparam logic [INSTR_W-1:0] NOP_PAT     = 12'h000;
    localparam logic [INSTR_W-1:0] NOP_MASK    = 12'hfff;
    localparam logic [INSTR_W-1:0] STORE_PAT   = 12'h020;
    localparam logic [INSTR_W-1:0] STORE_MASK  = 12'hfe0;
    localparam logic [INSTR_W-1:0] OR_F_PAT    = 12'h100;
    localparam logic [INSTR_W-1:0] MOVE_F_PAT  = 12'h200;
    localparam logic [INSTR_W-1:0] INC_SKZ_PAT = 12'h3c0;
    localparam logic [INSTR_W-1:0] FD_MASK     = 12'hfc0;
    localparam logic [INSTR_W-1:0] JUMP_PAT    = 12'ha00;
    localparam logic [INSTR_W-1:0] JUMP_MASK   = 12'he00;
    localparam logic [INSTR_W-1:0] LOAD_L_PAT  = 12'hc00;
    localparam logic [INSTR_W-1:0] OR_L_PAT    = 12'hd00;
    localparam logic [INSTR_W-1:0] LIT_MASK    = 12'hf00;

    // values after reset, and the increment constants ONE and PC_STEP
    localparam logic [PC_W-1:0]    PC_RST      = 11'h000;
    localparam logic [DATA_W-1:0]  ACC_RST     = 8'h00;
    localparam logic               ZERO_RST    = 1'b0;
    localparam logic [DATA_W-1:0]  ONE         = 8'h01;
    localparam logic [PC_W-1:0]    PC_STEP     = 11'h001;

    typedef enum logic [2:0] {
        OP_NOP,
        OP_STORE_ACC,
        OP_OR_FILE,
        OP_MOVE_FILE,
        OP_INC_SKZ,
        OP_JUMP,
        OP_LOAD_LIT,
        OP_OR_LIT
    } op_e;

    // one executed result, as the datapath hands it to the sequencer
    typedef struct packed {
        logic              accWr;
        logic              fileWr;
        logic [DATA_W-1:0] value;
        logic              zeroWr;
        logic              zero;
        logic              skip;
    } exec_s;

endpackage : mi_exec_pkg

// ==== verilog/mi_alu.sv ====
// Purpose: datapath for the executed subset, purely combinational
// Assumes: fileRd already holds the register addressed by the instruction
// Notes:   no flag other than zero is ever touched here
`timescale 1ns/1ps
module mi_alu
    import mi_exec_pkg::*;
(
    // decoded instruction
    input  wire op_e                op,
    input  wire logic [INSTR_W-1:0] instr,
    // operands
    input  wire logic [DATA_W-1:0]  acc,
    input  wire logic [DATA_W-1:0]  fileRd,
    // result
    output exec_s                   res
);

    wire logic              toFile;
    wire logic [DATA_W-1:0] literal;
    wire logic [DATA_W-1:0] incSum;
    wire logic [DATA_W-1:0] orFile;
    wire logic [DATA_W-1:0] orLit;

    assign toFile  = instr[DEST_BIT];
    assign literal = instr[LIT_LSB +: DATA_W];
    assign incSum  = fileRd + ONE;
    assign orFile  = acc | fileRd;
    assign orLit   = acc | literal;

    always_comb begin
        res = '0;
        unique case (op)
            OP_INC_SKZ: begin
                res.value  = incSum;
                res.accWr  = !toFile;
                res.fileWr = toFile;
                res.skip   = (incSum == '0);
            end
            OP_OR_LIT: begin
                res.value  = orLit;
                res.accWr  = 1'b1;
                res.zeroWr = 1'b1;
                res.zero   = (orLit == '0);
            end
            OP_OR_FILE: begin
                res.value  = orFile;
                res.accWr  = !toFile;
                res.fileWr = toFile;
                res.zeroWr = 1'b1;
                res.zero   = (orFile == '0);
            end
            OP_STORE_ACC: begin
                res.value  = acc;
                res.fileWr = 1'b1;
            end
            OP_MOVE_FILE: begin
                // writing the unchanged value back keeps it intact
                res.value  = fileRd;
                res.accWr  = !toFile;
                res.fileWr = toFile;
                res.zeroWr = 1'b1;
                res.zero   = (fileRd == '0);
            end
            OP_LOAD_LIT: begin
                res.value  = literal;
                res.accWr  = 1'b1;
            end
            OP_NOP, OP_JUMP: begin
                res = '0;
            end
        endcase
    end

endmodule : mi_alu

// ==== tb/mi_exec_properties.sv ====
// Purpose: port properties of mi_exec
// Assumes: one clock, srst synchronous active high
// Notes:   squashed slots left out of opcode terms, they run as nop
`timescale 1ns/1ps
module mi_exec_properties
    import mi_exec_pkg::*;
(
    // clock and reset
    input wire logic               clk,
    input wire logic               srst,
    // from fetch
    input wire logic               instrValid,
    input wire logic [INSTR_W-1:0] instr,
    input wire logic [DATA_W-1:0]  fileRdData,
    input wire logic [PAGE_W-1:0]  statusPage,
    // results
    input wire logic               fileWrEn,
    input wire logic [FADDR_W-1:0] fileWrAddr,
    input wire logic [DATA_W-1:0]  fileWrData,
    input wire logic [DATA_W-1:0]  acc,
    input wire logic               zeroFlag,
    input wire logic               zeroWrEn,
    input wire logic [PC_W-1:0]    pc,
    input wire logic               squash,
    input wire logic               illegal
);
    wire logic live    = instrValid && !squash;
    wire logic isLoad  = live && (instr & LIT_MASK) == LOAD_L_PAT;
    wire logic isOrL   = live && (instr & LIT_MASK) == OR_L_PAT;
    wire logic isJump  = live && (instr & JUMP_MASK) == JUMP_PAT;
    wire logic isInc   = live && (instr & FD_MASK) == INC_SKZ_PAT;
    wire logic isStore = live && (instr & STORE_MASK) == STORE_PAT;
    wire logic isMove  = live && (instr & FD_MASK) == MOVE_F_PAT;
    wire logic isOrF   = live && (instr & FD_MASK) == OR_F_PAT;
    wire logic isNop   = live && instr == NOP_PAT;
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    property p_load; isLoad |=> acc == $past(instr[7:0]) && !zeroWrEn; endproperty
    a_load: assert property (p_load) else $error("load result wrong");
    property p_orl;
        isOrL |=> acc == ($past(acc) | $past(instr[7:0])) && zeroWrEn
            && zeroFlag == (acc == 8'h00);
    endproperty
    a_orl: assert property (p_orl) else $error("or literal wrong");
    property p_jump;
        isJump |=> pc == {$past(statusPage), $past(instr[8:0])} && squash && !zeroWrEn;
    endproperty
    a_jump: assert property (p_jump) else $error("jump target wrong");
    property p_drop;
        squash && instrValid |=> !fileWrEn && !zeroWrEn && !squash && pc == $past(pc) + PC_STEP;
    endproperty
    a_drop: assert property (p_drop) else $error("discarded slot acted");
    property p_skip; isInc |=> squash == ($past(fileRdData) == 8'hff) && !zeroWrEn; endproperty
    a_skip: assert property (p_skip) else $error("skip decision wrong");
    property p_store;
        isStore |=> fileWrEn && fileWrData == $past(acc) && fileWrAddr == $past(instr[4:0])
            && !zeroWrEn;
    endproperty
    a_store: assert property (p_store) else $error("store wrong");
    property p_move;
        isMove |=> zeroWrEn && zeroFlag == ($past(fileRdData) == 8'h00)
            && fileWrEn == $past(instr[DEST_BIT]);
    endproperty
    a_move: assert property (p_move) else $error("move file wrong");
    property p_orf;
        isOrF |=> zeroWrEn && zeroFlag == (($past(acc) | $past(fileRdData)) == 8'h00)
            && fileWrEn == $past(instr[DEST_BIT]);
    endproperty
    a_orf: assert property (p_orf) else $error("or file wrong");
    property p_nop;
        isNop |=> !fileWrEn && !zeroWrEn && $stable(acc) && pc == $past(pc) + PC_STEP;
    endproperty
    a_nop: assert property (p_nop) else $error("nop changed state");
    c_skip: cover property (isInc ##1 squash);
    c_jump: cover property (isJump);
    c_test: cover property (isMove && instr[DEST_BIT]);
endmodule : mi_exec_properties

bind mi_exec mi_exec_properties u_props (.clk(clk), .srst(srst), .instrValid(instrValid),
    .instr(instr), .fileRdData(fileRdData), .statusPage(statusPage), .fileWrEn(fileWrEn),
    .fileWrAddr(fileWrAddr), .fileWrData(fileWrData), .acc(acc), .zeroFlag(zeroFlag),
    .zeroWrEn(zeroWrEn), .pc(pc), .squash(squash), .illegal(illegal));

// ==== tb/tb_top.sv ====
// Purpose: directed bench for mi_exec
// Assumes: bench stands in for fetch and register file
// Notes:   pc expectation tracked here from reset, never read back
`timescale 1ns/1ps
module tb_top
    import mi_exec_pkg::*;
;
    logic clk = 1'b0, srst = 1'b1, instrValid = 1'b0;
    logic [INSTR_W-1:0] instr = '0;
    logic [DATA_W-1:0]  fileRdData = '0, fileWrData, acc;
    logic [PAGE_W-1:0]  statusPage = '0;
    logic [FADDR_W-1:0] fileWrAddr;
    logic [PC_W-1:0]    pc, pcExp = '0;
    logic               fileWrEn, zeroFlag, zeroWrEn, squash, illegal;
    int                 failures = 0, comparisons = 0;
    always #5 clk = ~clk;
    mi_exec u_dut (.clk(clk), .srst(srst), .instrValid(instrValid), .instr(instr),
        .fileRdData(fileRdData), .statusPage(statusPage), .fileWrEn(fileWrEn),
        .fileWrAddr(fileWrAddr), .fileWrData(fileWrData), .acc(acc), .zeroFlag(zeroFlag),
        .zeroWrEn(zeroWrEn), .pc(pc), .squash(squash), .illegal(illegal));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic wrap_up;
        $display("failures=%0d comparisons=%0d", failures, comparisons);
        if (failures == 0 && comparisons > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : wrap_up
    // one slot per call, valid dropped after so nothing runs twice
    task automatic step(input logic [11:0] w, input logic [7:0] f, input logic jmp);
        @(posedge clk);
        instrValid <= 1'b1;
        instr <= w;
        fileRdData <= f;
        @(posedge clk);
        instrValid <= 1'b0;
        #1;
        pcExp = jmp ? {statusPage, w[8:0]} : pcExp + 11'h001;
        check(pc, pcExp);
    endtask : step
    task automatic t_literals;
        logic [7:0] lits [3] = '{8'h00, 8'hff, 8'h5a};
        foreach (lits[i]) begin
            step(LOAD_L_PAT | {4'h0, lits[i]}, 8'h00, 1'b0);
            check(acc, lits[i]);
            check(zeroWrEn, 1'b0);
        end
        step(LOAD_L_PAT, 8'h00, 1'b0);
        step(OR_L_PAT, 8'h00, 1'b0);
        check({zeroWrEn, zeroFlag, acc}, 10'h300);
        step(OR_L_PAT | 12'h081, 8'h00, 1'b0);
        check({zeroFlag, acc}, 9'h081);
    endtask : t_literals
    task automatic t_files;
        step(OR_F_PAT | 12'h023, 8'h14, 1'b0);
        check({fileWrEn, fileWrAddr, fileWrData, acc}, 22'h239581);
        step(OR_F_PAT | 12'h007, 8'h14, 1'b0);
        check({fileWrEn, acc}, 9'h095);
        step(STORE_PAT | 12'h01f, 8'h00, 1'b0);
        check({fileWrEn, fileWrAddr, fileWrData, zeroWrEn}, 15'h7f2a);
        step(MOVE_F_PAT | 12'h004, 8'h00, 1'b0);
        check({fileWrEn, zeroWrEn, zeroFlag, acc}, 11'h300);
        step(MOVE_F_PAT | 12'h02a, 8'h3c, 1'b0);
        check({fileWrEn, zeroFlag, fileWrData, acc}, 18'h23c00);
    endtask : t_files
    task automatic t_skip;
        step(INC_SKZ_PAT | 12'h005, 8'h41, 1'b0);
        check({squash, zeroWrEn, acc}, 10'h042);
        step(INC_SKZ_PAT | 12'h025, 8'hff, 1'b0);
        check({fileWrEn, squash, zeroFlag, fileWrData}, 11'h600);
        step(LOAD_L_PAT | 12'h077, 8'h00, 1'b0);
        check({fileWrEn, squash, acc}, 10'h042);
    endtask : t_skip
    task automatic t_jump;
        logic [8:0] ks [4] = '{9'h000, 9'h1ff, 9'h155, 9'h0aa};
        foreach (ks[i]) begin
            @(posedge clk);
            statusPage <= 2'(i);
            step(JUMP_PAT | {3'h0, ks[i]}, 8'h00, 1'b1);
            check(squash, 1'b1);
            step(MOVE_F_PAT | 12'h022, 8'h00, 1'b0);
            check({fileWrEn, zeroWrEn, squash, acc}, 11'h042);
        end
    endtask : t_jump
    task automatic t_quiet;
        step(NOP_PAT, 8'hff, 1'b0);
        check({fileWrEn, zeroWrEn, squash, acc}, 11'h042);
        step(12'hfff, 8'h00, 1'b0);
        check({illegal, fileWrEn, acc}, 10'h242);
        // idle slots must leave the counter alone
        repeat (3) @(posedge clk);
        #1;
        check(pc, pcExp);
    endtask : t_quiet
    initial begin
        repeat (12) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        #1;
        check({acc, zeroFlag, squash, pc}, 21'h0);
        t_literals();
        t_files();
        t_skip();
        t_jump();
        t_quiet();
        wrap_up();
    end
    initial begin
        repeat (5000) @(posedge clk);
        failures++;
        wrap_up();
    end
endmodule : tb_top
